// >>> pkg/cus_pkg.sv
// constants for the card unit startup and restart sequencer
// assumes one 40 MHz clock shared with the backplane host logic
package cus_pkg;
    // clock rate and documented startup times
    localparam longint CLK_HZ = 40000000;
    localparam longint STARTUP_S = 25;
    localparam longint NET_STARTUP_S = 35;
    localparam longint STARTUP_CYC = STARTUP_S * CLK_HZ;
    localparam longint NET_STARTUP_CYC = NET_STARTUP_S * CLK_HZ;
    localparam int CNT_W = 32;

    // host status word layout
    localparam int HSW_W = 16;
    localparam int HSW_XFER_EN = 0;
    localparam int HSW_RECOG_L0 = 1;
    localparam int HSW_LINK_OP = 2;
    localparam int HSW_RECOG_L1 = 4;

    // host control word restart bits per operating level
    localparam int HCW_W = 16;
    localparam int HCW_RESTART_L0 = 11;
    localparam int HCW_RESTART_L1 = 10;

    // system switch positions, index 0 is position 1
    localparam int SW_W = 6;
    localparam int SW_LEVEL = 0;

    // calendar clock width
    localparam int CAL_W = 32;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_HSW = 8'h08;
    localparam logic [7:0] OFF_CLOCK = 8'h0c;
    localparam logic [7:0] OFF_ELAPSED = 8'h10;

    // control register fields
    localparam int CTRL_NET = 0;
    localparam int CTRL_ERR_FORCE = 1;
    localparam int CTRL_ERR_CLR = 2;
    localparam int CTRL_RESTART = 3;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // status register fields
    localparam int ST_RUN = 0;
    localparam int ST_ERR = 1;
    localparam int ST_LEVEL = 2;
    localparam int ST_LOADING = 3;
    localparam int ST_PENDING = 4;
    localparam int ST_SW_BAD = 5;

    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {CUS_BOOT, CUS_LOAD, CUS_RUN} cus_state_t;
endpackage

// >>> hw/cus_sequencer.sv
// startup and restart sequencer of the memory-card expansion unit
// assumes host backplane signals run on clock; switches are async pins
// How it works
// - startup begins by itself after power-on reset, no start command
// - host-recognised sets status bit 01 at level 0, bit 04 at level 1
// - transfer enable flag set right after power-on, before startup ends
// - data-link-operating flag set at power-on, cleared when run lights
// - host instructions wait and only execute once run is on
// - startup lasts 25 s, or 35 s with the networking option
// - host drops control bit 11 (level 0) or 10 (level 1) to restart
// - after every restart the host calendar is copied to the unit clock
// - run indicator on after startup, error indicator on an error
// - slot activity indicator lit while that slot's card is accessed
// - switch 1 off selects level 1, on level 0; held while operating
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
module cus_sequencer
    import cus_pkg::*;
#(
    parameter logic [CNT_W-1:0] STARTUP_CYCLES = CNT_W'(STARTUP_CYC),
    parameter logic [CNT_W-1:0] NET_STARTUP_CYCLES = CNT_W'(NET_STARTUP_CYC)
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // host side
    input wire logic [HCW_W-1:0] host_control_word,
    input wire logic host_recognised,
    input wire logic [CAL_W-1:0] host_calendar,
    input wire logic instr_req,
    output logic instr_go,
    output logic [HSW_W-1:0] host_status_word,
    // front panel and cards
    input wire logic [SW_W-1:0] system_switch,
    input wire logic error_detect,
    input wire logic slot_one_busy,
    input wire logic slot_two_busy,
    output logic run_led,
    output logic err_led,
    output logic slot_one_activity,
    output logic slot_two_activity
);
    cus_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [SW_W-1:0] sw_meta_reg, sw_sync_reg;
    logic level_reg, level_next;
    logic sw_bad_reg, sw_bad_next;
    logic restart_bit_reg, restart_bit_next;
    logic [HSW_W-1:0] hsw_reg, hsw_next;
    logic [CAL_W-1:0] clock_reg, clock_next;
    logic run_reg, run_next;
    logic err_reg, err_next;
    logic pending_reg, pending_next;
    logic go_reg, go_next;
    logic act1_reg, act1_next, act2_reg, act2_next;
    logic [1:0] ctrl_reg, ctrl_next;
    logic soft_restart;
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] wr_addr_reg, wr_addr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic addr_phase;
    logic restart_fall;
    logic sel_bit;
    logic [CNT_W-1:0] limit;

    // switch pins pass two flip-flops before use; no reset, so the pins
    // are already through the pair when the boot cycle reads them
    always_ff @(posedge clock) begin
        if (ce) begin
            sw_meta_reg <= system_switch;
            sw_sync_reg <= sw_meta_reg;
        end
    end

    // restart source selected by the held operating level
    assign sel_bit = level_reg ? host_control_word[HCW_RESTART_L1]
                               : host_control_word[HCW_RESTART_L0];
    assign restart_fall = restart_bit_reg & ~sel_bit;
    assign limit = ctrl_reg[CTRL_NET] ? NET_STARTUP_CYCLES : STARTUP_CYCLES;
    assign addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ);
    assign soft_restart = wr_pend_reg & (wr_addr_reg == OFF_CTRL) & hwdata[CTRL_RESTART];

    // sequencer, flags, indicators and bus next values
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        level_next = level_reg;
        sw_bad_next = sw_bad_reg;
        restart_bit_next = sel_bit;
        hsw_next = hsw_reg;
        clock_next = clock_reg;
        run_next = run_reg;
        err_next = err_reg;
        pending_next = pending_reg;
        go_next = 1'b0;
        ctrl_next = ctrl_reg;
        wr_pend_next = 1'b0;
        wr_addr_next = wr_addr_reg;
        rdata_next = 32'h0;
        // a fresh run of startup; the first pass follows reset by itself
        unique case (state_reg)
            CUS_BOOT: begin
                level_next = ~sw_sync_reg[SW_LEVEL];
                // no stale edge when the level changes
                restart_bit_next = 1'b0;
                sw_bad_next = |sw_sync_reg[SW_W-1:1];
                clock_next = host_calendar;
                cnt_next = '0;
                run_next = 1'b0;
                hsw_next = '0;
                hsw_next[HSW_XFER_EN] = 1'b1;
                hsw_next[HSW_LINK_OP] = 1'b1;
                state_next = CUS_LOAD;
            end
            CUS_LOAD: begin
                cnt_next = cnt_reg + CNT_W'(1);
                if (cnt_reg >= limit - CNT_W'(1)) begin
                    run_next = 1'b1;
                    hsw_next[HSW_LINK_OP] = 1'b0;
                    state_next = CUS_RUN;
                end
            end
            CUS_RUN: begin
            end
        endcase
        // recognition bit by operating level
        if (host_recognised && state_reg != CUS_BOOT) begin
            if (level_reg) begin
                hsw_next[HSW_RECOG_L1] = 1'b1;
            end else begin
                hsw_next[HSW_RECOG_L0] = 1'b1;
            end
        end
        // instructions are held until run is on
        if (run_reg && pending_reg) begin
            go_next = 1'b1;
            pending_next = 1'b0;
        end
        if (instr_req) begin
            pending_next = 1'b1;
        end
        // restart drops run; a go cut short stays pending
        if ((restart_fall || soft_restart) && state_reg != CUS_BOOT) begin
            state_next = CUS_BOOT;
            run_next = 1'b0;
            go_next = 1'b0;
            pending_next = pending_reg | instr_req;
        end
        // register writes in the data phase
        if (wr_pend_reg && wr_addr_reg == OFF_CTRL) begin
            ctrl_next = hwdata[1:0];
            if (hwdata[CTRL_ERR_CLR]) begin
                err_next = 1'b0;
            end
        end
        // error sources win over the clear
        if (error_detect || ctrl_reg[CTRL_ERR_FORCE] || sw_bad_reg) begin
            err_next = 1'b1;
        end
        act1_next = slot_one_busy;
        act2_next = slot_two_busy;
        // address phase: latch writes, prepare read data
        if (addr_phase) begin
            wr_pend_next = hwrite;
            wr_addr_next = haddr[7:0];
            if (!hwrite && haddr[31:8] == 24'h0) begin
                unique case (haddr[7:0])
                    OFF_CTRL: rdata_next = {30'h0, ctrl_reg};
                    OFF_STATUS: begin
                        rdata_next[ST_RUN] = run_reg;
                        rdata_next[ST_ERR] = err_reg;
                        rdata_next[ST_LEVEL] = level_reg;
                        rdata_next[ST_LOADING] = (state_reg == CUS_LOAD);
                        rdata_next[ST_PENDING] = pending_reg;
                        rdata_next[ST_SW_BAD] = sw_bad_reg;
                    end
                    OFF_HSW: rdata_next = {16'h0, hsw_reg};
                    OFF_CLOCK: rdata_next = clock_reg;
                    OFF_ELAPSED: rdata_next = cnt_reg;
                    default: rdata_next = 32'h0;
                endcase
            end
        end
    end

    // state registers; ce low freezes everything but srst
    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= CUS_BOOT;
            cnt_reg <= '0;
            level_reg <= 1'b0;
            sw_bad_reg <= 1'b0;
            restart_bit_reg <= 1'b0;
            hsw_reg <= '0;
            clock_reg <= '0;
            run_reg <= 1'b0;
            err_reg <= 1'b0;
            pending_reg <= 1'b0;
            go_reg <= 1'b0;
            act1_reg <= 1'b0;
            act2_reg <= 1'b0;
            ctrl_reg <= CTRL_RESET;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h0;
            rdata_reg <= 32'h0;
        end else if (ce) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            level_reg <= level_next;
            sw_bad_reg <= sw_bad_next;
            restart_bit_reg <= restart_bit_next;
            hsw_reg <= hsw_next;
            clock_reg <= clock_next;
            run_reg <= run_next;
            err_reg <= err_next;
            pending_reg <= pending_next;
            go_reg <= go_next;
            act1_reg <= act1_next;
            act2_reg <= act2_next;
            ctrl_reg <= ctrl_next;
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            rdata_reg <= rdata_next;
        end
    end

    // outputs straight from flip-flops, ready and response tied to constants; zero wait states
    assign hrdata = rdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign instr_go = go_reg;
    assign host_status_word = hsw_reg;
    assign run_led = run_reg;
    assign err_led = err_reg;
    assign slot_one_activity = act1_reg;
    assign slot_two_activity = act2_reg;
endmodule

// >>> tb/cus_sequencer_asserts.sv
// port checker for the startup and restart sequencer
// assumes ce high and switches moved only while srst is high
`timescale 1ns/10ps
module cus_sequencer_asserts
    import cus_pkg::*;
#(
    parameter logic [CNT_W-1:0] STARTUP_CYCLES = 32'd20,
    parameter logic [CNT_W-1:0] NET_STARTUP_CYCLES = 32'd30
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [HCW_W-1:0] host_control_word,
    input wire logic host_recognised,
    input wire logic [SW_W-1:0] system_switch,
    input wire logic error_detect,
    input wire logic instr_go,
    input wire logic [HSW_W-1:0] host_status_word,
    input wire logic run_led,
    input wire logic err_led
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    logic [CNT_W-1:0] low_reg, low_next;
    // cycles the run indicator has been dark
    always_comb low_next = (srst || run_led) ? '0 : low_reg + 1'b1;
    always_ff @(posedge clock) low_reg <= low_next;

    a_startup_time: assert property ($rose(run_led) |->
        (low_reg - STARTUP_CYCLES < 4) || (low_reg - NET_STARTUP_CYCLES < 4))
        else $error("run lit after wrong delay");
    a_restart_lvl0: assert property ($fell(host_control_word[11]) && system_switch[0]
        && run_led |-> ##2 !run_led) else $error("no restart at level 0");
    a_restart_lvl1: assert property ($fell(host_control_word[10]) && !system_switch[0]
        && run_led |-> ##2 !run_led) else $error("no restart at level 1");
    a_edge_ignored: assert property (($rose(host_control_word[11]) ||
        $fell(host_control_word[10])) && system_switch[0] && run_led |=> run_led)
        else $error("restart on wrong edge");
    a_boot_flags: assert property ($fell(run_led) |=> host_status_word == 16'h0005)
        else $error("status word wrong after restart");
    a_link_clear: assert property ($rose(run_led) |-> !host_status_word[2]
        && $past(host_status_word[2])) else $error("link flag not cleared at run");
    a_go_run: assert property (instr_go |-> run_led)
        else $error("instruction ran before run");
    a_recog_bit: assert property (host_recognised && run_led ##2 run_led |->
        host_status_word[1] == system_switch[0] && host_status_word[4] == !system_switch[0])
        else $error("recognition bit wrong");
    a_err_lamp: assert property (error_detect |-> ##[1:2] err_led)
        else $error("error indicator not lit");
    c_run: cover property ($rose(run_led));
    c_go: cover property (instr_go);
    c_restart: cover property ($fell(run_led));
endmodule

// >>> tb/cus_host_model.sv
// host controller model: control word, recognition, calendar, requests
// assumes the bench calls its tasks just after a rising edge
`timescale 1ns/10ps
module cus_host_model
    import cus_pkg::*;
(
    input wire logic clock,
    output logic [HCW_W-1:0] host_control_word,
    output logic host_recognised,
    output logic [CAL_W-1:0] host_calendar,
    output logic instr_req
);
    // idle host at time zero
    initial begin
        host_control_word = '0;
        host_recognised = 1'b0;
        host_calendar = 32'h0;
        instr_req = 1'b0;
    end
    // one control bit per edge; a drop from one asks for restart
    task automatic put(input int b, input logic v);
        @(posedge clock);
        host_control_word[b] <= v;
    endtask
    // calendar value and recognition level, changed at an edge
    task automatic cal(input logic [CAL_W-1:0] v);
        host_calendar <= v;
    endtask
    task automatic recog(input logic v);
        host_recognised <= v;
    endtask
    // one-cycle instruction request
    task automatic req();
        @(posedge clock);
        instr_req <= 1'b1;
        @(posedge clock);
        instr_req <= 1'b0;
    endtask
endmodule

// >>> tb/card_unit_startup_restart_tb_top.sv
// testbench top: sequencer, host model, bus master and checks
// assumes a zero-wait bus slave and shortened startup counts
`timescale 1ns/10ps
module card_unit_startup_restart_tb_top;
    import cus_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic error_detect = 1'b0;
    logic slot_one_busy = 1'b0;
    logic slot_two_busy = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [5:0] system_switch = 6'h01;
    logic [31:0] hrdata, rd, cal;
    logic [15:0] hcw, hsw;
    logic hreadyout, hresp, rec, req, instr_go, run_led, err_led, act1, act2;
    int n_fail = 0;
    int num_checks = 0;
    int c;
    // bus clock
    always #12.5 clock = ~clock;
    cus_host_model host (.clock(clock), .host_control_word(hcw), .host_recognised(rec),
        .host_calendar(cal), .instr_req(req));
    cus_sequencer #(.STARTUP_CYCLES(32'd20), .NET_STARTUP_CYCLES(32'd30)) uut (
        .clock(clock), .srst(srst), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .host_control_word(hcw), .host_recognised(rec),
        .host_calendar(cal), .instr_req(req), .instr_go(instr_go), .host_status_word(hsw),
        .system_switch(system_switch), .error_detect(error_detect),
        .slot_one_busy(slot_one_busy), .slot_two_busy(slot_two_busy), .run_led(run_led),
        .err_led(err_led), .slot_one_activity(act1), .slot_two_activity(act2));
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic tmo();
        n_fail++;
        results();
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // wait for the rising edge at which ready is sampled high
    task automatic wrdy();
        int i;
        i = 0;
        @(posedge clock);
        while (hreadyout !== 1'b1) begin
            i++;
            if (i > 50) tmo();
            @(posedge clock);
        end
    endtask
    // single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        wrdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wrdy();
        // read data and response taken at the edge that ends the data phase
        rd = hrdata;
        chk("resp", hresp, 1'b0);
    endtask
    // reset with switch 1 giving the level, the rest off
    task automatic rst(input logic l);
        @(posedge clock);
        srst <= 1'b1;
        system_switch <= {5'h0, l};
        repeat (8) @(posedge clock);
        srst <= 1'b0;
    endtask
    // count dark cycles until the run indicator lights
    task automatic wrun();
        int i;
        c = 0;
        for (i = 0; !(c > 0 && run_led === 1'b1); i++) begin
            if (i > 100) tmo();
            @(negedge clock);
            c += int'(run_led === 1'b0);
        end
    endtask
    task automatic restart(input int b);
        host.put(b, 1'b1);
        host.put(b, 1'b0);
        wrun();
    endtask
    // power-on, instructions, restarts, error and level 1
    initial begin
        host.cal(32'h1234_5678);
        rst(1'b1);
        repeat (3) @(negedge clock);
        chk("flags", hsw, 16'h5);
        host.req();
        wrun();
        for (c = 0; c < 5 && instr_go !== 1'b1; c++) @(negedge clock);
        chk("go", instr_go, 1'b1);
        chk("flags", hsw, 16'h1);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk("status", rd, 32'h1);
        bus(1'b0, OFF_CLOCK, 32'h0);
        chk("clock", rd, 32'h1234_5678);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped", rd, 32'h0);
        @(posedge clock);
        host.recog(1'b1);
        repeat (3) @(negedge clock);
        chk("recog", hsw, 16'h3);
        host.put(11, 1'b1);
        host.put(10, 1'b1);
        host.put(10, 1'b0);
        repeat (3) @(negedge clock);
        chk("run", run_led, 1'b1);
        @(posedge clock);
        host.cal(32'h5a5a_0001);
        host.put(11, 1'b0);
        wrun();
        chk("dark", c, 21);
        bus(1'b0, OFF_CLOCK, 32'h0);
        chk("clock", rd, 32'h5a5a_0001);
        bus(1'b1, OFF_CTRL, 32'h1);
        restart(11);
        chk("dark", c, 31);
        @(posedge clock);
        error_detect <= 1'b1;
        slot_one_busy <= 1'b1;
        @(posedge clock);
        error_detect <= 1'b0;
        repeat (2) @(negedge clock);
        chk("err", err_led, 1'b1);
        chk("slot", act1, 1'b1);
        chk("slot", act2, 1'b0);
        bus(1'b1, OFF_CTRL, 32'h5);
        repeat (2) @(negedge clock);
        chk("err", err_led, 1'b0);
        // error forced through the control register
        bus(1'b1, OFF_CTRL, 32'h2);
        repeat (2) @(negedge clock);
        chk("err", err_led, 1'b1);
        // slot one access ends and slot two goes busy at the same edge
        @(posedge clock);
        slot_one_busy <= 1'b0;
        slot_two_busy <= 1'b1;
        repeat (2) @(negedge clock);
        chk("slot", act1, 1'b0);
        chk("slot", act2, 1'b1);
        rst(1'b0);
        wrun();
        bus(1'b0, OFF_STATUS, 32'h0);
        chk("status", rd, 32'h5);
        chk("recog", hsw, 16'h11);
        restart(10);
        chk("dark", c, 21);
        // software restart through the control register, calendar copied again
        @(posedge clock);
        host.cal(32'h0f0f_00a5);
        bus(1'b1, OFF_CTRL, 32'h8);
        wrun();
        chk("dark", c, 21);
        bus(1'b0, OFF_CLOCK, 32'h0);
        chk("clock", rd, 32'h0f0f_00a5);
        results();
    end
endmodule
bind cus_sequencer cus_sequencer_asserts #(.STARTUP_CYCLES(STARTUP_CYCLES),
    .NET_STARTUP_CYCLES(NET_STARTUP_CYCLES)) chk_i (.clock(clock), .srst(srst),
    .host_control_word(host_control_word), .host_recognised(host_recognised),
    .system_switch(system_switch), .error_detect(error_detect), .instr_go(instr_go),
    .host_status_word(host_status_word), .run_led(run_led), .err_led(err_led));
